// >>> verif/pbsp_engine_model.sv
`timescale 1ns/1ns
// ==========================================================
// Downstream link engine: finishes each request after delay
module pbsp_engine_model (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       req_valid,
   input  wire logic [7:0] delay,
   output logic            req_done
);
   logic [7:0] wait_reg;

   // Pulse only, so a finished request is never answered twice
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_reg <= 8'h00;
         req_done <= 1'h0;
      end else begin
         req_done <= 1'h0;
         if (req_valid && !req_done) begin
            if (wait_reg == delay) begin
               req_done <= 1'h1;
               wait_reg <= 8'h00;
            end else begin
               wait_reg <= wait_reg + 8'h01;
            end
         end
      end
   end
endmodule : pbsp_engine_model

// >>> verif/testbench.sv
`timescale 1ns/1ns
module testbench;
   // ==========================================================
   // Signals
   logic                clk = 1'h0, sys_rst = 1'h1;
   logic                rdc = 1'h0, dis = 1'h0, link = 1'h0;
   logic [31:0]         addr = 32'h0000_0000, wdata = 32'h0000_0000;
   logic [3:0]          be = 4'h0;
   logic                sel = 1'h0, lq = 1'h0, fw = 1'h0, rd = 1'h0;
   logic [9:0]          len = 10'h000;
   logic                loc = 1'h0, rem = 1'h0, done, cmpl, busy;
   logic [7:0]          dly = 8'h00;
   logic                sc_pe_n, req_valid;
   logic [3:0]          rx_pe_n;
   pbsp_pkg::pbsp_req_t req_out;
   int                  n_fail = 0, check_count = 0;

   always #5 clk = ~clk;

   pbsp_slave_port pbsp_slave_port_inst (
      .clk(clk), .sys_rst(sys_rst), .remote_drives_clock(rdc),
      .clock_pullup_disable(dis), .link_established(link),
      .host_address_bus(addr), .host_write_data_bus(wdata),
      .host_byte_lane_enables(be), .host_transfer_select(sel),
      .host_lane_transfer_qualifier(lq), .host_full_word_qualifier(fw),
      .host_read_direction(rd), .host_packet_remaining_bytes(len),
      .target_local_registers(loc), .target_remote_link(rem),
      .serial_clock_pullup_enable_n(sc_pe_n),
      .receive_lane_pullup_enable_n(rx_pe_n), .host_bus_busy(busy),
      .req_valid(req_valid), .req_out(req_out), .req_done(done),
      .xfer_complete(cmpl));

   pbsp_engine_model pbsp_engine_model_inst (.clk(clk), .sys_rst(sys_rst),
      .req_valid(req_valid), .delay(dly), .req_done(done));

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_of_test;
      if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   // ==========================================================
   // Scenarios
   task automatic pullups;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         rdc <= i[0];
         dis <= i[1];
         link <= i[2];
         @(posedge clk);
         #1;
         chk(sc_pe_n, (i[1] || !i[0]) ? 1'h1 : 1'h0);
         chk(rx_pe_n, i[2] ? 4'hf : 4'h0);
      end
   endtask : pullups

   // Request lines busy but select low: nothing may start
   task automatic select_low;
      @(posedge clk);
      addr <= 32'h1234_5678;
      be <= 4'hf;
      lq <= 1'h1;
      repeat (3) begin
         @(posedge clk);
         #1;
         chk(req_valid, 1'h0);
         chk(busy, 1'h0);
      end
   endtask : select_low

   task automatic xfer(input logic [31:0] a, d, input logic [3:0] b,
                       input logic r, f, input logic [9:0] n,
                       input logic l, input logic [7:0] w);
      pbsp_pkg::pbsp_req_t e;
      int                  k;
      e = pbsp_pkg::REQ_ZERO;
      e.addr = a;
      e.lanes = b;
      e.read = r;
      e.full_word = f;
      e.remaining = n;
      e.to_local = l;
      e.to_remote = !l;
      for (int j = 0; j < 4; j++)
         if (b[j] && !r) e.wdata[8*j+:8] = d[8*j+:8];
      @(posedge clk);
      {dly, addr, wdata, be} <= {w, a, d, b};
      {rd, fw, len} <= {r, f, n};
      {loc, rem, lq, sel} <= {l, !l, 2'h3};
      k = 0;
      do begin @(posedge clk); #1; k++; end
      while (req_valid !== 1'h1 && k < 20);
      chk(req_out, e);
      chk(busy, 1'h1);
      k = 0;
      do begin @(posedge clk); #1; k++; end
      while (cmpl !== 1'h1 && k < 50);
      chk({cmpl, req_valid, busy}, 3'h5);
      @(posedge clk);
      sel <= 1'h0;
      #1;
      chk({cmpl, busy}, 2'h1);
      @(posedge clk);
      #1;
      chk(busy, 1'h0);
   endtask : xfer

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      pullups();
      select_low();
      xfer(32'h0000_1001, 32'haabb_ccdd, 4'h6, 1'h0, 1'h0, 10'h002, 1'h1,
           8'h00);
      xfer(32'h8000_0000, 32'h1122_3344, 4'hf, 1'h1, 1'h1, 10'h3ff, 1'h0,
           8'h05);
      xfer(32'h0000_0003, 32'h5566_7788, 4'h8, 1'h0, 1'h0, 10'h001, 1'h0,
           8'h02);
      xfer(32'hffff_fffc, 32'h99aa_bbcc, 4'h3, 1'h0, 1'h0, 10'h004, 1'h1,
           8'h01);
      end_of_test();
   end

   // Whole run is under a hundred cycles; this leaves wide margin
   initial begin
      #100000;
      n_fail++;
      end_of_test();
   end
endmodule : testbench

// >>> verilog/pbsp_pkg.sv
package pbsp_pkg;

   // ==========================================================
   // Widths
   localparam int ADDR_W  = 32;
   localparam int DATA_W  = 32;
   localparam int LANES   = 4;
   localparam int LEN_W   = 10;
   localparam int RXD_W   = 4;

   // ==========================================================
   // Reset and idle values
   localparam logic [ADDR_W-1:0] ADDR_ZERO     = 32'h0000_0000;
   localparam logic [DATA_W-1:0] DATA_ZERO     = 32'h0000_0000;
   localparam logic [LANES-1:0]  LANES_ALL     = 4'hf;
   localparam logic [LANES-1:0]  LANES_NONE    = 4'h0;
   localparam logic [LEN_W-1:0]  LEN_ZERO      = 10'h000;
   localparam logic              CLK_PE_N_RST  = 1'h1;
   localparam logic [RXD_W-1:0]  RXD_PE_ON     = 4'h0;
   localparam logic [RXD_W-1:0]  RXD_PE_OFF    = 4'hf;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      PBSP_IDLE,
      PBSP_PEND,
      PBSP_DRAIN
   } pbsp_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [LANES-1:0]  lanes;
      logic              read;
      logic              full_word;
      logic [LEN_W-1:0]  remaining;
      logic              to_local;
      logic              to_remote;
   } pbsp_req_t;

   localparam pbsp_req_t REQ_ZERO = '{
      addr: ADDR_ZERO, wdata: DATA_ZERO, lanes: LANES_NONE,
      read: 1'h0, full_word: 1'h0, remaining: LEN_ZERO,
      to_local: 1'h0, to_remote: 1'h0};

endpackage : pbsp_pkg

// >>> verilog/pbsp_slave_port.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Clock pullup enable low when remote end drives clock, else high.
// - Pullup-disable control forces clock pullup enable high.
// - Receive pullup enables low until link is up, then high.
// - Busy is high while any transfer is pending or running.
// - Write data comes from the 32-bit write data bus.
// - Byte enable i validates bits 7+8i..8i; only those lanes used when the lane qualifier is set.
// - Unaligned multi-byte accesses in one transfer are accepted.
// - Request inputs count only while select is high.
// - With lane qualifier, exactly the flagged lanes are transferred.
// - Direction high means read, low means write.
module pbsp_slave_port (
   input  wire logic                              clk,
   input  wire logic                              sys_rst,
   input  wire logic                              remote_drives_clock,
   input  wire logic                              clock_pullup_disable,
   input  wire logic                              link_established,
   input  wire logic [pbsp_pkg::ADDR_W-1:0]       host_address_bus,
   input  wire logic [pbsp_pkg::DATA_W-1:0]       host_write_data_bus,
   input  wire logic [pbsp_pkg::LANES-1:0]        host_byte_lane_enables,
   input  wire logic                              host_transfer_select,
   input  wire logic                              host_lane_transfer_qualifier,
   input  wire logic                              host_full_word_qualifier,
   input  wire logic                              host_read_direction,
   input  wire logic [pbsp_pkg::LEN_W-1:0]        host_packet_remaining_bytes,
   input  wire logic                              target_local_registers,
   input  wire logic                              target_remote_link,
   output logic                                   serial_clock_pullup_enable_n,
   output logic [pbsp_pkg::RXD_W-1:0]             receive_lane_pullup_enable_n,
   output logic                                   host_bus_busy,
   output logic                                   req_valid,
   output pbsp_pkg::pbsp_req_t                    req_out,
   input  wire logic                              req_done,
   output logic                                   xfer_complete
);

   // ==========================================================
   // State
   pbsp_pkg::pbsp_state_t state_reg;
   pbsp_pkg::pbsp_state_t state_next;
   pbsp_pkg::pbsp_req_t   req_reg;
   pbsp_pkg::pbsp_req_t   req_next;
   logic                  clk_pe_n_reg;
   logic [pbsp_pkg::RXD_W-1:0] rxd_pe_n_reg;
   logic                  done_reg;

   // ==========================================================
   // Decode
   wire logic                        take_req;
   wire logic [pbsp_pkg::LANES-1:0]  eff_lanes;
   wire logic [pbsp_pkg::DATA_W-1:0] lane_mask;
   wire logic                        clk_pe_n_next;
   wire logic [pbsp_pkg::RXD_W-1:0]  rxd_pe_n_next;

   // Inputs are looked at only in idle with select high
   assign take_req = (state_reg == pbsp_pkg::PBSP_IDLE)
                     && host_transfer_select;

   // Full word without lane qualifier means all four lanes
   assign eff_lanes = host_lane_transfer_qualifier
                      ? host_byte_lane_enables
                      : (host_full_word_qualifier ? pbsp_pkg::LANES_ALL
                                                  : pbsp_pkg::LANES_NONE);

   // Any lane pattern goes, so unaligned spans pass as one transfer
   assign lane_mask = {{8{eff_lanes[3]}}, {8{eff_lanes[2]}},
                       {8{eff_lanes[1]}}, {8{eff_lanes[0]}}};

   assign clk_pe_n_next = clock_pullup_disable
                          || !remote_drives_clock;
   assign rxd_pe_n_next = link_established ? pbsp_pkg::RXD_PE_OFF
                                           : pbsp_pkg::RXD_PE_ON;

   always_comb begin
      req_next = req_reg;
      if (take_req) begin
         req_next.addr      = host_address_bus;
         // Read data never comes from the write bus
         req_next.wdata     = host_read_direction ? pbsp_pkg::DATA_ZERO
                              : (host_write_data_bus & lane_mask);
         req_next.lanes     = eff_lanes;
         req_next.read      = host_read_direction;
         req_next.full_word = host_full_word_qualifier;
         req_next.remaining = host_packet_remaining_bytes;
         req_next.to_local  = target_local_registers;
         req_next.to_remote = target_remote_link;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         pbsp_pkg::PBSP_IDLE: begin
            if (take_req) begin
               state_next = pbsp_pkg::PBSP_PEND;
            end
         end
         pbsp_pkg::PBSP_PEND: begin
            if (req_done) begin
               state_next = pbsp_pkg::PBSP_DRAIN;
            end
         end
         // Select stays up until completion; wait for it to fall
         pbsp_pkg::PBSP_DRAIN: begin
            if (!host_transfer_select) begin
               state_next = pbsp_pkg::PBSP_IDLE;
            end
         end
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg    <= pbsp_pkg::PBSP_IDLE;
         req_reg      <= pbsp_pkg::REQ_ZERO;
         clk_pe_n_reg <= pbsp_pkg::CLK_PE_N_RST;
         rxd_pe_n_reg <= pbsp_pkg::RXD_PE_ON;
         done_reg     <= 1'h0;
      end else begin
         state_reg    <= state_next;
         req_reg      <= req_next;
         clk_pe_n_reg <= clk_pe_n_next;
         rxd_pe_n_reg <= rxd_pe_n_next;
         done_reg     <= (state_reg == pbsp_pkg::PBSP_PEND) && req_done;
      end
   end

   // ==========================================================
   // Outputs
   assign serial_clock_pullup_enable_n = clk_pe_n_reg;
   assign receive_lane_pullup_enable_n = rxd_pe_n_reg;
   // Combinational so a fresh select shows busy at once
   assign host_bus_busy = host_transfer_select
                          || (state_reg != pbsp_pkg::PBSP_IDLE);
   assign req_valid     = (state_reg == pbsp_pkg::PBSP_PEND);
   assign req_out       = req_reg;
   assign xfer_complete = done_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Output seen just after release still holds its reset value
   a_clk_pullup_dir: assert property (
      !$past(sys_rst) && !$past(clock_pullup_disable) |->
      serial_clock_pullup_enable_n == !$past(remote_drives_clock))
      else $error("clock pullup enable does not follow direction");

   a_clk_pullup_off: assert property (
      clock_pullup_disable |=> serial_clock_pullup_enable_n)
      else $error("clock pullup not disabled by control");

   a_rxd_pullup_link: assert property (
      ##1 receive_lane_pullup_enable_n ==
      ($past(link_established) ? pbsp_pkg::RXD_PE_OFF
                               : pbsp_pkg::RXD_PE_ON))
      else $error("receive pullups do not follow link state");

   a_busy_pending: assert property (
      req_valid || xfer_complete |-> host_bus_busy)
      else $error("busy dropped while transfer pending");

   a_busy_bound: assert property (
      req_valid && req_done |=> host_bus_busy && xfer_complete)
      else $error("completion not flagged one cycle after done");

   a_write_lanes: assert property (
      take_req && !host_read_direction && host_lane_transfer_qualifier
      |=> req_valid && req_out.lanes == $past(host_byte_lane_enables)
          && req_out.wdata == ($past(host_write_data_bus)
             & {{8{$past(host_byte_lane_enables[3])}},
                {8{$past(host_byte_lane_enables[2])}},
                {8{$past(host_byte_lane_enables[1])}},
                {8{$past(host_byte_lane_enables[0])}}}))
      else $error("write lanes not taken as enabled");

   a_read_no_data: assert property (
      take_req && host_read_direction |=> req_out.read
      && req_out.wdata == pbsp_pkg::DATA_ZERO)
      else $error("read request carries write data");

   a_hold_request: assert property (
      req_valid && !req_done |=> req_valid && $stable(req_out))
      else $error("request changed while pending");

   a_idle_no_take: assert property (
      !host_transfer_select && state_reg == pbsp_pkg::PBSP_IDLE
      |=> !req_valid)
      else $error("request taken without select");

   a_unaligned_ok: assert property (
      take_req && host_lane_transfer_qualifier
      && host_byte_lane_enables == 4'h6 |=> req_out.lanes == 4'h6)
      else $error("unaligned lanes not accepted");

   a_drain_busy: assert property (
      xfer_complete |-> host_bus_busy && !req_valid)
      else $error("completion seen without busy or with request");

   // A held select after completion must not start a second transfer
   a_no_retake: assert property (
      state_reg == pbsp_pkg::PBSP_DRAIN && host_transfer_select
      |=> !req_valid)
      else $error("new request taken before select dropped");

   a_complete_pulse: assert property (
      xfer_complete |=> !xfer_complete)
      else $error("completion flag held longer than one cycle");

   c_write: cover property (take_req && !host_read_direction
                            ##[1:20] xfer_complete);
   c_read: cover property (take_req && host_read_direction
                           ##[1:20] xfer_complete);
   c_link_up: cover property ($rose(link_established));
   c_remote_clk: cover property (!serial_clock_pullup_enable_n);

endmodule : pbsp_slave_port
